/* File: hw/countdown_timer.sv */
// Purpose: Loadable down counter used for the warning and ramp delays
// Assumes: start is a one-cycle pulse from the same clock
// Notes:   busy is high while the count is non-zero
`timescale 1ns/100ps
`default_nettype none
module countdown_timer #(
    parameter int W = 22
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic         start,
    input  wire logic [W-1:0] load_value,
    output logic              busy
);
    logic [W-1:0] count;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            count <= '0;
        end else if (start) begin
            count <= load_value;
        end else if (count != '0) begin
            count <= count - W'(1);
        end
    end

    assign busy = (count != '0);
endmodule
`default_nettype wire

/* File: hw/supply_config_trim_registers.sv */
// Purpose: Monitor pin and soft-start/share trim registers with shadow download
// Assumes: Serial port front end gives byte-wide register strobes
// Notes:   Pin inputs pass three flops; a change counts when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module supply_config_trim_registers #(
    parameter int CLK_MHZ = 50
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        test_download,
    output logic             ee_req,
    output logic      [15:0] ee_addr,
    input  wire logic        ee_ack,
    input  wire logic [7:0]  ee_data,
    output logic             load_busy,
    input  wire logic        mains_good_signal,
    input  wire logic        mon_above_dac,
    input  wire logic        supply_ok_req,
    output logic             mon_pin_out,
    output logic             mon_pin_oe,
    output logic             manufacturing_flag,
    output logic             mon_ov,
    output logic             mon_uv,
    output logic             output_good_signal,
    output logic             ramp_active,
    output logic      [1:0]  power_off_warn_delay,
    output logic      [2:0]  share_capture_pct,
    output logic      [1:0]  ramp_time_sel,
    output logic             second_addr_select,
    output logic      [1:0]  pin_on_debounce_sel
);
    localparam int TW = supply_trim_pkg::TIMER_W;

    supply_trim_pkg::load_state_e load_state;
    logic [7:0] mon_cfg;
    logic [7:0] trim_cfg;
    logic       trim_locked;
    logic       trim_wr_ok;
    logic [2:0] sync_mains;
    logic [2:0] sync_cmp;
    logic [2:0] sync_ok;
    logic       mains_f;
    logic       cmp_f;
    logic       ok_f;
    logic       ok_prev;
    logic       warn_busy;
    logic       ramp_busy;
    logic       ok_rise;
    logic       ok_fall;
    logic [2:0] mon_sel;

    function automatic logic [TW-1:0] us_cycles(input int us);
        us_cycles = TW'(us * CLK_MHZ);
    endfunction

    function automatic logic [TW-1:0] warn_cycles(input logic [1:0] code);
        case (code)
            2'h0:    warn_cycles = us_cycles(supply_trim_pkg::WARN_MS_0 * supply_trim_pkg::US_PER_MS);
            2'h1:    warn_cycles = us_cycles(supply_trim_pkg::WARN_MS_1 * supply_trim_pkg::US_PER_MS);
            2'h2:    warn_cycles = us_cycles(supply_trim_pkg::WARN_MS_2 * supply_trim_pkg::US_PER_MS);
            default: warn_cycles = us_cycles(supply_trim_pkg::WARN_MS_3 * supply_trim_pkg::US_PER_MS);
        endcase
    endfunction

    function automatic logic [TW-1:0] ramp_cycles(input logic [1:0] code);
        case (code)
            2'h0:    ramp_cycles = us_cycles(supply_trim_pkg::RAMP_US_0);
            2'h1:    ramp_cycles = us_cycles(supply_trim_pkg::RAMP_US_1);
            2'h2:    ramp_cycles = us_cycles(supply_trim_pkg::RAMP_US_2);
            default: ramp_cycles = us_cycles(supply_trim_pkg::RAMP_US_3);
        endcase
    endfunction

    // Shadow download sequence
    always_ff @(posedge clock) begin
        if (!nrst) begin
            load_state <= supply_trim_pkg::LOAD_MON;
        end else begin
            case (load_state)
                supply_trim_pkg::LOAD_IDLE: begin
                    if (test_download) begin
                        load_state <= supply_trim_pkg::LOAD_MON;
                    end
                end
                supply_trim_pkg::LOAD_MON: begin
                    if (ee_ack) begin
                        load_state <= supply_trim_pkg::LOAD_TRIM;
                    end
                end
                supply_trim_pkg::LOAD_TRIM: begin
                    if (ee_ack) begin
                        load_state <= supply_trim_pkg::LOAD_IDLE;
                    end
                end
                default: load_state <= supply_trim_pkg::LOAD_IDLE;
            endcase
        end
    end

    assign load_busy = (load_state != supply_trim_pkg::LOAD_IDLE);
    assign ee_req    = load_busy;
    assign ee_addr   = (load_state == supply_trim_pkg::LOAD_TRIM) ? supply_trim_pkg::TRIM_CFG_EE_ADDR
                                                                 : supply_trim_pkg::MON_CFG_EE_ADDR;

    // Register writes; download has priority over the serial port
    assign trim_locked = trim_cfg[supply_trim_pkg::LOCK_BIT];
    assign trim_wr_ok  = reg_wr && !trim_locked && !load_busy;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            mon_cfg <= supply_trim_pkg::CFG_RESET;
        end else if (load_state == supply_trim_pkg::LOAD_MON && ee_ack) begin
            mon_cfg <= ee_data;
        end else if (trim_wr_ok && reg_addr == supply_trim_pkg::MON_CFG_ADDR) begin
            mon_cfg <= reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            trim_cfg <= supply_trim_pkg::CFG_RESET;
        end else if (load_state == supply_trim_pkg::LOAD_TRIM && ee_ack) begin
            trim_cfg <= ee_data;
        end else if (trim_wr_ok && reg_addr == supply_trim_pkg::TRIM_CFG_ADDR) begin
            trim_cfg <= reg_wdata;
        end
    end

    // Register reads, one cycle after the strobe
    always_ff @(posedge clock) begin
        if (!nrst) begin
            reg_rdata <= supply_trim_pkg::READ_UNMAPPED;
        end else if (reg_rd) begin
            case (reg_addr)
                supply_trim_pkg::MON_CFG_ADDR:  reg_rdata <= mon_cfg;
                supply_trim_pkg::TRIM_CFG_ADDR: reg_rdata <= trim_cfg;
                default:                        reg_rdata <= supply_trim_pkg::READ_UNMAPPED;
            endcase
        end
    end

    // Field decode
    assign power_off_warn_delay = trim_cfg[supply_trim_pkg::WARN_HI:supply_trim_pkg::WARN_LO];
    assign share_capture_pct    = {1'b0, trim_cfg[supply_trim_pkg::BAND_HI:supply_trim_pkg::BAND_LO]} + 3'h1;
    assign ramp_time_sel        = trim_cfg[supply_trim_pkg::RAMP_HI:supply_trim_pkg::RAMP_LO];
    assign second_addr_select   = trim_cfg[supply_trim_pkg::ADDR_BIT];
    assign pin_on_debounce_sel  = mon_cfg[supply_trim_pkg::DEB_HI:supply_trim_pkg::DEB_LO];
    assign mon_sel              = mon_cfg[supply_trim_pkg::MON_HI:supply_trim_pkg::MON_LO];

    // Pin synchronisers
    always_ff @(posedge clock) begin
        if (!nrst) begin
            sync_mains <= '0;
            sync_cmp   <= '0;
            sync_ok    <= '0;
        end else begin
            sync_mains <= {sync_mains[1:0], mains_good_signal};
            sync_cmp   <= {sync_cmp[1:0], mon_above_dac};
            sync_ok    <= {sync_ok[1:0], supply_ok_req};
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            mains_f <= 1'b0;
            cmp_f   <= 1'b0;
            ok_f    <= 1'b0;
            ok_prev <= 1'b0;
        end else begin
            if (sync_mains[2] == sync_mains[1]) begin
                mains_f <= sync_mains[2];
            end
            if (sync_cmp[2] == sync_cmp[1]) begin
                cmp_f <= sync_cmp[2];
            end
            if (sync_ok[2] == sync_ok[1]) begin
                ok_f <= sync_ok[2];
            end
            ok_prev <= ok_f;
        end
    end

    // Monitor pin function
    always_ff @(posedge clock) begin
        if (!nrst) begin
            mon_pin_out        <= 1'b0;
            mon_pin_oe         <= 1'b0;
            manufacturing_flag <= 1'b0;
            mon_ov             <= 1'b0;
            mon_uv             <= 1'b0;
        end else begin
            mon_pin_out        <= mains_f;
            mon_pin_oe         <= (mon_sel == supply_trim_pkg::MON_MAINS_A) || (mon_sel == supply_trim_pkg::MON_MAINS_B);
            manufacturing_flag <= cmp_f && (mon_sel >= supply_trim_pkg::MON_POS_OV)
                                        && (mon_sel != supply_trim_pkg::MON_OFF);
            mon_ov             <= (mon_sel == supply_trim_pkg::MON_POS_OV && cmp_f)
                               || (mon_sel == supply_trim_pkg::MON_NEG_OV && !cmp_f);
            mon_uv             <= (mon_sel == supply_trim_pkg::MON_POS_UV && !cmp_f)
                               || (mon_sel == supply_trim_pkg::MON_NEG_UV && cmp_f);
        end
    end

    // Soft-start ramp and power-off warning
    assign ok_rise = ok_f && !ok_prev;
    assign ok_fall = !ok_f && ok_prev;

    countdown_timer #(.W(TW)) ramp_timer (
        .clock      (clock),
        .nrst       (nrst),
        .start      (ok_rise),
        .load_value (ramp_cycles(ramp_time_sel)),
        .busy       (ramp_busy)
    );

    countdown_timer #(.W(TW)) warn_timer (
        .clock      (clock),
        .nrst       (nrst),
        .start      (ok_fall),
        .load_value (warn_cycles(power_off_warn_delay)),
        .busy       (warn_busy)
    );

    assign ramp_active = ramp_busy;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            output_good_signal <= 1'b0;
        end else if (ok_f && !ok_rise && !ramp_busy) begin
            output_good_signal <= 1'b1;
        end else if (!ok_f && !ok_fall && !warn_busy) begin
            output_good_signal <= 1'b0;
        end
    end

    // Checks
    sequence s_load_mon;
        load_state == supply_trim_pkg::LOAD_MON && ee_ack;
    endsequence

    sequence s_load_trim;
        load_state == supply_trim_pkg::LOAD_TRIM && ee_ack;
    endsequence

    a_load_mon_copy: assert property (@(posedge clock) disable iff (!nrst)
        s_load_mon |=> mon_cfg == $past(ee_data))
        else $error("monitor register not loaded from shadow");
    a_load_trim_copy: assert property (@(posedge clock) disable iff (!nrst)
        s_load_trim |=> trim_cfg == $past(ee_data) && !load_busy)
        else $error("trim register not loaded from shadow");
    a_lock_blocks_write: assert property (@(posedge clock) disable iff (!nrst)
        trim_locked && !load_busy |=> $stable(trim_cfg) && $stable(mon_cfg))
        else $error("write accepted while locked");
    a_trim_write_taken: assert property (@(posedge clock) disable iff (!nrst)
        reg_wr && !trim_locked && !load_busy && reg_addr == supply_trim_pkg::TRIM_CFG_ADDR
        |=> trim_cfg == $past(reg_wdata))
        else $error("unlocked write lost");
    a_warn_holds_good: assert property (@(posedge clock) disable iff (!nrst)
        output_good_signal && warn_busy |=> output_good_signal)
        else $error("output good dropped during warning delay");
    a_ramp_blocks_good: assert property (@(posedge clock) disable iff (!nrst)
        ok_rise && !output_good_signal && ramp_cycles(ramp_time_sel) > TW'(2) |=> !output_good_signal [*2])
        else $error("output good rose during ramp");
    a_band_decode: assert property (@(posedge clock) disable iff (!nrst)
        trim_cfg[supply_trim_pkg::BAND_HI:supply_trim_pkg::BAND_LO] == 2'h3 |-> share_capture_pct == 3'h4)
        else $error("share band decode wrong");
    a_pos_ov_flags: assert property (@(posedge clock) disable iff (!nrst)
        mon_sel == supply_trim_pkg::MON_POS_OV && cmp_f && $stable(mon_sel) |=> mon_ov && manufacturing_flag && !mon_uv)
        else $error("positive overvoltage indication wrong");
    a_addr_bit_follows: assert property (@(posedge clock) disable iff (!nrst)
        s_load_trim |=> second_addr_select == $past(ee_data[supply_trim_pkg::ADDR_BIT]))
        else $error("address bit not from register");
endmodule
`default_nettype wire

/* File: hw/supply_trim_pkg.sv */
// Purpose: Shared constants for the supply trim register bank
// Assumes: 50 MHz system clock
// Notes:   Times are kept in their own units; cycle counts are derived in the bank
package supply_trim_pkg;
    // Register offsets on the serial port and their non-volatile shadows
    localparam logic [7:0]  MON_CFG_ADDR     = 8'h0F;
    localparam logic [7:0]  TRIM_CFG_ADDR    = 8'h10;
    localparam logic [15:0] MON_CFG_EE_ADDR  = 16'h810F;
    localparam logic [15:0] TRIM_CFG_EE_ADDR = 16'h8110;
    localparam logic [7:0]  CFG_RESET        = 8'h00;
    localparam logic [7:0]  READ_UNMAPPED    = 8'h00;

    // Field positions of the soft-start and share register
    localparam int WARN_HI  = 7;
    localparam int WARN_LO  = 6;
    localparam int BAND_HI  = 5;
    localparam int BAND_LO  = 4;
    localparam int RAMP_HI  = 3;
    localparam int RAMP_LO  = 2;
    localparam int ADDR_BIT = 1;
    localparam int LOCK_BIT = 0;

    // Field positions of the monitor pin register
    localparam int MON_HI = 4;
    localparam int MON_LO = 2;
    localparam int DEB_HI = 1;
    localparam int DEB_LO = 0;

    // Monitor pin function codes
    localparam logic [2:0] MON_MAINS_A = 3'h0;
    localparam logic [2:0] MON_MAINS_B = 3'h1;
    localparam logic [2:0] MON_POS_OV  = 3'h2;
    localparam logic [2:0] MON_POS_UV  = 3'h3;
    localparam logic [2:0] MON_NEG_OV  = 3'h4;
    localparam logic [2:0] MON_NEG_UV  = 3'h5;
    localparam logic [2:0] MON_FLAG    = 3'h6;
    localparam logic [2:0] MON_OFF     = 3'h7;

    // Power-off warning delays in ms, by code
    localparam int WARN_MS_0 = 2;
    localparam int WARN_MS_1 = 0;
    localparam int WARN_MS_2 = 1;
    localparam int WARN_MS_3 = 4;

    // Soft-start rise times in us, by code
    localparam int RAMP_US_0 = 300;
    localparam int RAMP_US_1 = 10000;
    localparam int RAMP_US_2 = 20000;
    localparam int RAMP_US_3 = 40000;

    localparam int US_PER_MS = 1000;
    localparam int TIMER_W   = 22;

    typedef enum logic [1:0] {LOAD_IDLE, LOAD_MON, LOAD_TRIM} load_state_e;
endpackage

/* File: sim/shadow_memory_model.sv */
// Purpose: Shadow byte store answering the download port
// Assumes: Same clock as the register bank
// Notes:   Data is inverted every idle cycle so stale bytes never match
`timescale 1ns/100ps
`default_nettype none
module shadow_memory_model (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        ee_req,
    input  wire logic [15:0] ee_addr,
    input  wire logic [7:0]  mon_byte,
    input  wire logic [7:0]  trim_byte,
    input  wire logic [3:0]  wait_cycles,
    output logic             ee_ack,
    output logic      [7:0]  ee_data
);
    logic [3:0] count;

    // Answers each request after wait_cycles idle cycles
    always_ff @(posedge clock) begin
        if (!nrst) begin
            count   <= 4'h0;
            ee_ack  <= 1'b0;
            ee_data <= 8'hA5;
        end else if (!ee_req || ee_ack) begin
            count   <= 4'h0;
            ee_ack  <= 1'b0;
            ee_data <= ~ee_data;
        end else if (count >= wait_cycles) begin
            ee_ack  <= 1'b1;
            ee_data <= (ee_addr == 16'h810F) ? mon_byte : trim_byte;
        end else begin
            count   <= count + 4'h1;
            ee_data <= ~ee_data;
        end
    end
endmodule
`default_nettype wire

/* File: sim/supply_config_trim_registers_test.sv */
// Purpose: Self-checking bench for the supply trim register bank
// Assumes: Bank built with CLK_MHZ of 1, one cycle per microsecond
// Notes:   Checks sample at the falling edge
`timescale 1ns/100ps
`default_nettype none
module supply_config_trim_registers_test;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        test_download = 1'b0;
    logic        mains_good_signal = 1'b1;
    logic        mon_above_dac = 1'b0;
    logic        supply_ok_req = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  mon_byte = 8'h09;
    logic [7:0]  trim_byte = 8'hE6;
    logic [3:0]  wait_cycles = 4'h3;
    logic        ee_req, ee_ack, load_busy, mon_pin_out, mon_pin_oe, manufacturing_flag;
    logic        mon_ov, mon_uv, output_good_signal, ramp_active, second_addr_select;
    logic [7:0]  reg_rdata, ee_data;
    logic [15:0] ee_addr;
    logic [1:0]  power_off_warn_delay, ramp_time_sel, pin_on_debounce_sel;
    logic [2:0]  share_capture_pct;
    int          n_fail = 0;
    int          compares = 0;
    int          warn_cyc [4] = '{2000, 0, 1000, 4000};

    always #10 clock = ~clock;

    supply_config_trim_registers #(.CLK_MHZ(1)) supply_config_trim_registers_inst (
        .clock, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .test_download,
        .ee_req, .ee_addr, .ee_ack, .ee_data, .load_busy, .mains_good_signal, .mon_above_dac,
        .supply_ok_req, .mon_pin_out, .mon_pin_oe, .manufacturing_flag, .mon_ov, .mon_uv,
        .output_good_signal, .ramp_active, .power_off_warn_delay, .share_capture_pct,
        .ramp_time_sel, .second_addr_select, .pin_on_debounce_sel);

    shadow_memory_model shadow_memory_model_inst (
        .clock, .nrst, .ee_req, .ee_addr, .mon_byte, .trim_byte, .wait_cycles, .ee_ack, .ee_data);

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(negedge clock);
    endtask

    task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        check($sformatf("register %h", a), exp, reg_rdata);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic wait_load;
        for (int i = 0; i < 60 && load_busy !== 1'b0; i++) @(negedge clock);
        check("load_busy", 8'h00, 8'(load_busy));
    endtask

    function automatic logic [2:0] mon_exp(input logic [2:0] c, input logic a);
        case (c)
            3'h2:    return a ? 3'b110 : 3'b000;
            3'h3:    return a ? 3'b100 : 3'b001;
            3'h4:    return a ? 3'b100 : 3'b010;
            3'h5:    return a ? 3'b101 : 3'b000;
            3'h6:    return a ? 3'b100 : 3'b000;
            default: return 3'b000;
        endcase
    endfunction

    task automatic finish_test;
        $display("compares %0d, n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #(20ns * 30000);
        n_fail++;
        finish_test();
    end

    initial begin
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        wait_load();
        check_reg(8'h0F, 8'h09);
        check_reg(8'h10, 8'hE6);
        check("address bit", 8'h01, 8'(second_addr_select));
        check("pin_on_debounce_sel", 8'h01, 8'(pin_on_debounce_sel));
        check_reg(8'h11, 8'h00);
        $display("power-up download done");
        for (int c = 0; c < 4; c++) begin
            write_reg(8'h10, 8'(c * 8'h54 + (c % 2) * 2));
            check("warn delay", 8'(c), 8'(power_off_warn_delay));
            check("share band", 8'(c + 1), 8'(share_capture_pct));
            check("ramp select", 8'(c), 8'(ramp_time_sel));
            check("address bit", 8'(c % 2), 8'(second_addr_select));
        end
        $display("field decode done");
        for (int c = 0; c < 8; c++) begin
            write_reg(8'h0F, 8'(c << 2));
            for (int a = 0; a < 2; a++) begin
                @(posedge clock);
                mon_above_dac     <= a[0];
                mains_good_signal <= a[0];
                settle(8);
                check("mon_pin_oe", 8'(c < 2), 8'(mon_pin_oe));
                if (c < 2) check("mon_pin_out", 8'(a), 8'(mon_pin_out));
                if (c > 1) check("mon flags", 8'(mon_exp(3'(c), a[0])),
                    8'({manufacturing_flag, mon_ov, mon_uv}));
            end
        end
        $display("monitor modes done");
        for (int c = 0; c < 4; c++) begin
            int rc;
            rc = (c == 1) ? 10000 : 300;
            write_reg(8'h10, 8'((c << 6) + ((c == 1) ? 4 : 0)));
            @(posedge clock);
            supply_ok_req <= 1'b1;
            settle(rc / 2);
            check("ramp_active", 8'h01, 8'(ramp_active));
            settle(rc / 2 - 10);
            check("good early", 8'h00, 8'(output_good_signal));
            settle(30);
            check("good on", 8'h01, 8'(output_good_signal));
            check("ramp done", 8'h00, 8'(ramp_active));
            @(posedge clock);
            supply_ok_req <= 1'b0;
            if (warn_cyc[c] > 0) begin
                settle(warn_cyc[c] - 5);
                check("good held", 8'h01, 8'(output_good_signal));
            end
            settle(20);
            check("good off", 8'h00, 8'(output_good_signal));
        end
        $display("output good timing done");
        write_reg(8'h10, 8'h5B);
        write_reg(8'h10, 8'h00);
        write_reg(8'h0F, 8'h0C);
        check_reg(8'h10, 8'h5B);
        check_reg(8'h0F, 8'h1C);
        trim_byte   = 8'h24;
        wait_cycles = 4'h9;
        @(posedge clock);
        test_download <= 1'b1;
        @(posedge clock);
        test_download <= 1'b0;
        settle(1);
        wait_load();
        check_reg(8'h0F, 8'h09);
        check_reg(8'h10, 8'h24);
        write_reg(8'h10, 8'h30);
        check_reg(8'h10, 8'h30);
        $display("trim lock done");
        @(posedge clock);
        nrst        <= 1'b0;
        wait_cycles <= 4'h0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        wait_load();
        check_reg(8'h10, 8'h24);
        check_reg(8'h0F, 8'h09);
        check("address bit", 8'h00, 8'(second_addr_select));
        $display("second reset done");
        finish_test();
    end
endmodule
`default_nettype wire
